//--- logic/samm_defs.svh
`ifndef SAMM_DEFS_SVH
`define SAMM_DEFS_SVH

`define SAMM_NAXES        16
`define SAMM_BANK_MON     8'h00
`define SAMM_BANK_AMP     8'h52
`define SAMM_OFS_MON_ID   16'h0390
`define SAMM_OFS_MON_CTRL 16'h0391
`define SAMM_OFS_MON_STAT 16'h0392
`define SAMM_OFS_MON_RSVD 16'h0393
`define SAMM_OFS_MON_DLO  16'h0394
`define SAMM_OFS_MON_DHI  16'h0395
`define SAMM_OFS_AMP_ID   16'h0000
`define SAMM_OFS_AMP_CTRL 16'h0001
`define SAMM_OFS_AMP_STAT 16'h0002
`define SAMM_REQ_NONE     16'h0000
`define SAMM_REQ_AMP_RST  16'h0006
`define SAMM_ST_IDLE      16'h0000
`define SAMM_ST_BUSY      16'h0001
`define SAMM_ST_OK        16'h0002
`define SAMM_ST_REFUSED   16'h0004
`define SAMM_ST_NET_FAIL  16'h0006

`endif

//--- logic/samm_mailbox.sv
// Summary of operation
// - Monitor area is bank 0 words 0x390 to 0x395.
// - Monitor requests are served while the axis is in motion.
// - No monitor service during homing; host must not request then.
// - Network disconnection error blocks monitor requests.
// - Accepting sets status 0x0001; returned value goes to data words.
// - Status 0x0002 means normal end; anything else is abnormal.
// - Codes 01,02,05,06,07 are basic servo items.
// - Codes 04,08,09,0A,0C are command and latch positions and speed.
// - Codes 11,12 loads; 21-24 logical I/O; 25,26 physical I/O.
// - Codes 31-34 tuning and warnings; 41-43 angle and turns.
// - Codes 61-69 lifetime and health items.
// - Code 71 network error count, 81 encoder error count.
// - Amplifier reset drops the network, errors all linked axes, servo-off.
// - Code 0x0006 at bank 0x52 offset 1 forwards amplifier reset.
// - Control word returns to 0x0000 when processing ends.
// - Failure stores status 0x0004 or 0x0006.
`timescale 1ns/100ps
`include "samm_defs.svh"

module samm_mailbox (
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire samm_pkg::samm_mem_req_s mem_req,
	output logic [15:0]                 mem_rdata,
	input  wire logic [15:0]            axis_link_present_flag,
	input  wire logic [15:0]            axis_motion_active_flag,
	input  wire logic [15:0]            axis_homing_flag,
	input  wire logic                   net_disconnect_err,
	input  wire logic                   axis_err_clear,
	output samm_pkg::samm_net_req_s     net_req,
	input  wire samm_pkg::samm_net_resp_s net_resp,
	output logic [15:0]                 axis_net_error,
	output logic                        servo_off_all,
	output logic                        busy
);
	import samm_pkg::*;

	samm_state_s cur_ff;
	samm_state_s nxt_cur;

	// Legal monitor type codes
	function automatic logic code_ok(input logic [15:0] c);
		logic r;
		r = 1'b0;
		if (c[15:8] == 8'h00) begin
			case (c[7:0])
				8'h01, 8'h02, 8'h05, 8'h06, 8'h07: r = 1'b1;
				8'h04, 8'h08, 8'h09, 8'h0a, 8'h0c: r = 1'b1;
				8'h11, 8'h12, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26: r = 1'b1;
				8'h31, 8'h32, 8'h33, 8'h34, 8'h41, 8'h42, 8'h43: r = 1'b1;
				8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69: r = 1'b1;
				8'h71, 8'h81: r = 1'b1;
				default: r = 1'b0;
			endcase
		end
		return r;
	endfunction

	function automatic logic hit(input samm_mem_req_s q, input logic [7:0] b, input logic [15:0] a);
		return (q.bank == b) && (q.addr == a);
	endfunction

	// Completion status shared by monitor and reset requests
	function automatic logic [15:0] done_stat(input logic ok);
		return ok ? `SAMM_ST_OK : `SAMM_ST_NET_FAIL;
	endfunction

	logic [15:0] ax_hit;
	logic        ax_homing;
	logic        ax_present;
	logic        mon_start;
	logic        mon_refuse;
	logic        rst_start;
	logic        rst_done;

	// Full id compare: ids beyond the axis range select nothing and are refused
	for (genvar g = 0; g < `SAMM_NAXES; g++) begin : g_axis
		assign ax_hit[g] = (cur_ff.mon_id == 16'(g));
	end

	always_comb begin
		ax_homing  = |(axis_homing_flag & ax_hit);
		ax_present = |(axis_link_present_flag & ax_hit);
		mon_start  = (cur_ff.st == SAMM_IDLE) && (cur_ff.mon_ctrl != `SAMM_REQ_NONE);
		// Motion flag deliberately not checked: monitoring runs during moves
		mon_refuse = !code_ok(cur_ff.mon_ctrl) || ax_homing || net_disconnect_err || !ax_present;
		rst_start  = (cur_ff.st == SAMM_IDLE) && (cur_ff.amp_ctrl == `SAMM_REQ_AMP_RST);
		rst_done   = (cur_ff.st == SAMM_WAIT) && cur_ff.rst_req && net_resp.valid && net_resp.ok;
	end

	always_comb begin
		nxt_cur = cur_ff;
		// Host writes land first; device updates below override them
		// Ids and codes feed the network request, so all of them freeze while busy
		if (mem_req.wr && cur_ff.st == SAMM_IDLE) begin
			if (hit(mem_req, `SAMM_BANK_MON, `SAMM_OFS_MON_ID)) begin
				nxt_cur.mon_id = mem_req.wdata;
			end
			if (hit(mem_req, `SAMM_BANK_MON, `SAMM_OFS_MON_CTRL)) begin
				nxt_cur.mon_ctrl = mem_req.wdata;
			end
			if (hit(mem_req, `SAMM_BANK_AMP, `SAMM_OFS_AMP_ID)) begin
				nxt_cur.amp_id = mem_req.wdata;
			end
			if (hit(mem_req, `SAMM_BANK_AMP, `SAMM_OFS_AMP_CTRL)) begin
				nxt_cur.amp_ctrl = mem_req.wdata;
			end
		end

		// Read data is registered, so it stands until the next read
		if (mem_req.rd) begin
			nxt_cur.rdata = 16'h0000;
			if (mem_req.bank == `SAMM_BANK_MON) begin
				case (mem_req.addr)
					`SAMM_OFS_MON_ID:   nxt_cur.rdata = cur_ff.mon_id;
					`SAMM_OFS_MON_CTRL: nxt_cur.rdata = cur_ff.mon_ctrl;
					`SAMM_OFS_MON_STAT: nxt_cur.rdata = cur_ff.mon_stat;
					`SAMM_OFS_MON_DLO:  nxt_cur.rdata = cur_ff.mon_data[15:0];
					`SAMM_OFS_MON_DHI:  nxt_cur.rdata = cur_ff.mon_data[31:16];
					default:            nxt_cur.rdata = 16'h0000;
				endcase
			end else if (mem_req.bank == `SAMM_BANK_AMP) begin
				case (mem_req.addr)
					`SAMM_OFS_AMP_ID:   nxt_cur.rdata = cur_ff.amp_id;
					`SAMM_OFS_AMP_CTRL: nxt_cur.rdata = cur_ff.amp_ctrl;
					`SAMM_OFS_AMP_STAT: nxt_cur.rdata = cur_ff.amp_stat;
					default:            nxt_cur.rdata = 16'h0000;
				endcase
			end
		end

		case (cur_ff.st)
			SAMM_IDLE: begin
				// Reset request has priority; it takes the whole network down anyway
				if (rst_start) begin
					nxt_cur.rst_req  = 1'b1;
					nxt_cur.amp_stat = `SAMM_ST_BUSY;
					nxt_cur.st       = SAMM_SEND;
				end else if (cur_ff.amp_ctrl != `SAMM_REQ_NONE) begin
					nxt_cur.amp_ctrl = `SAMM_REQ_NONE;
					nxt_cur.amp_stat = `SAMM_ST_REFUSED;
				end else if (mon_start) begin
					nxt_cur.rst_req = 1'b0;
					if (mon_refuse) begin
						nxt_cur.mon_ctrl = `SAMM_REQ_NONE;
						nxt_cur.mon_stat = `SAMM_ST_REFUSED;
					end else begin
						nxt_cur.mon_stat = `SAMM_ST_BUSY;
						nxt_cur.st       = SAMM_SEND;
					end
				end
			end
			SAMM_SEND: begin
				// One-cycle send pulse; the answer is only taken in WAIT
				nxt_cur.st = SAMM_WAIT;
			end
			SAMM_WAIT: begin
				if (!cur_ff.rst_req && net_disconnect_err) begin
					nxt_cur.mon_ctrl = `SAMM_REQ_NONE;
					nxt_cur.mon_stat = `SAMM_ST_NET_FAIL;
					nxt_cur.st       = SAMM_IDLE;
				end else if (net_resp.valid) begin
					nxt_cur.st = SAMM_IDLE;
					if (cur_ff.rst_req) begin
						nxt_cur.amp_ctrl = `SAMM_REQ_NONE;
						nxt_cur.amp_stat = done_stat(net_resp.ok);
						if (net_resp.ok) begin
							nxt_cur.axis_err  = axis_link_present_flag;
							nxt_cur.servo_off = 1'b1;
						end
					end else begin
						nxt_cur.mon_ctrl = `SAMM_REQ_NONE;
						nxt_cur.mon_stat = done_stat(net_resp.ok);
						// A failed answer keeps the last good value for the host
						if (net_resp.ok) begin
							nxt_cur.mon_data = net_resp.data;
						end
					end
				end
			end
			default: begin
				nxt_cur.st = SAMM_IDLE;
			end
		endcase

		// Clear drops errors, but a fresh reset completion in the same cycle wins
		if (axis_err_clear && !rst_done) begin
			nxt_cur.axis_err  = 16'h0000;
			nxt_cur.servo_off = 1'b0;
		end
	end

	// Async reset clears every word; nothing is pending after it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cur_ff <= '{st: SAMM_IDLE, default: '0};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	always_comb begin
		net_req.valid     = (cur_ff.st == SAMM_SEND);
		net_req.amp_reset = cur_ff.rst_req;
		net_req.axis      = cur_ff.rst_req ? cur_ff.amp_id : cur_ff.mon_id;
		net_req.code      = cur_ff.rst_req ? cur_ff.amp_ctrl[7:0] : cur_ff.mon_ctrl[7:0];
		mem_rdata         = cur_ff.rdata;
		axis_net_error    = cur_ff.axis_err;
		servo_off_all     = cur_ff.servo_off;
		busy              = (cur_ff.st != SAMM_IDLE);
	end

	// Motion flags are read only here; no refusal depends on them
	logic unused_motion;
	assign unused_motion = |axis_motion_active_flag;
endmodule

//--- logic/samm_pkg.sv
package samm_pkg;
	typedef enum logic [1:0] {
		SAMM_IDLE = 2'b00,
		SAMM_SEND = 2'b01,
		SAMM_WAIT = 2'b10
	} samm_state_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  bank;
		logic [15:0] addr;
		logic [15:0] wdata;
	} samm_mem_req_s;

	typedef struct packed {
		logic        valid;
		logic        amp_reset;
		logic [15:0] axis;
		logic [7:0]  code;
	} samm_net_req_s;

	typedef struct packed {
		logic        valid;
		logic        ok;
		logic [31:0] data;
	} samm_net_resp_s;

	typedef struct packed {
		samm_state_e st;
		logic        rst_req;
		logic [15:0] mon_id;
		logic [15:0] mon_ctrl;
		logic [15:0] mon_stat;
		logic [31:0] mon_data;
		logic [15:0] amp_id;
		logic [15:0] amp_ctrl;
		logic [15:0] amp_stat;
		logic [15:0] rdata;
		logic [15:0] axis_err;
		logic        servo_off;
	} samm_state_s;
endpackage

//--- test/samm_amp_model.sv
`timescale 1ns/100ps
module samm_amp_model (
	input  wire logic                     sys_clk,
	input  wire logic                     rstn,
	input  wire samm_pkg::samm_net_req_s  net_req,
	input  wire logic [3:0]               dly,
	input  wire logic                     fail,
	output samm_pkg::samm_net_resp_s      net_resp
);
	import samm_pkg::*;
	logic [4:0]    cnt;
	samm_net_req_s held;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			cnt <= 5'h00;
		else if (net_req.valid) begin
			cnt  <= {1'b0, dly} + 5'h01;
			held <= net_req;
		end else if (cnt != 5'h00)
			cnt <= cnt - 5'h01;
	end
	assign net_resp.valid = cnt == 5'h01;
	assign net_resp.ok    = !fail;
	// Data between answers tracks the countdown and is zero when idle, so a stale word cannot pass as fresh
	assign net_resp.data  = net_resp.valid ? {held.code, 8'h5a, held.axis} : {8{cnt[3:0]}};
endmodule

//--- test/samm_mailbox_chk.sv
`timescale 1ns/100ps
module samm_mailbox_chk (
	input wire logic                     sys_clk,
	input wire logic                     rstn,
	input wire samm_pkg::samm_net_req_s  net_req,
	input wire samm_pkg::samm_net_resp_s net_resp,
	input wire logic [15:0]              axis_link_present_flag,
	input wire logic [15:0]              axis_homing_flag,
	input wire logic                     net_disconnect_err,
	input wire logic [15:0]              axis_net_error,
	input wire logic                     servo_off_all,
	input wire logic                     busy
);
	import samm_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_wait;
		busy && !net_req.valid;
	endsequence
	sequence s_mon_go;
		net_req.valid && !net_req.amp_reset;
	endsequence
	a_send_on_start: assert property ($rose(busy) |-> net_req.valid)
		else $error("no send at start");
	a_send_one_cycle: assert property (net_req.valid |=> !net_req.valid)
		else $error("send pulse too long");
	a_homing_blocks: assert property (s_mon_go |-> !axis_homing_flag[net_req.axis[3:0]])
		else $error("send during homing");
	a_link_blocks: assert property (s_mon_go |-> axis_link_present_flag[net_req.axis[3:0]] && !net_disconnect_err)
		else $error("send without link");
	a_req_stable: assert property (busy && !$rose(busy) |-> $stable(net_req.code) && $stable(net_req.axis))
		else $error("request moved while busy");
	a_resp_ends: assert property (s_wait ##0 net_resp.valid |=> !busy)
		else $error("answer did not end request");
	a_reset_marks: assert property (s_wait ##0 net_req.amp_reset && net_resp.ok && net_resp.valid
		|=> servo_off_all && axis_net_error == $past(axis_link_present_flag)) else $error("reset marks wrong");
	a_busy_bounded: assert property ($rose(busy) |-> ##[1:40] !busy)
		else $error("request never ended");
endmodule
bind samm_mailbox samm_mailbox_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .net_req(net_req), .net_resp(net_resp),
	.axis_link_present_flag(axis_link_present_flag), .axis_homing_flag(axis_homing_flag),
	.net_disconnect_err(net_disconnect_err), .axis_net_error(axis_net_error), .servo_off_all(servo_off_all),
	.busy(busy));

//--- test/samm_mailbox_tb_top.sv
`timescale 1ns/100ps
module samm_mailbox_tb_top;
	import samm_pkg::*;
	logic           sys_clk = 1'b0, rstn = 1'b0, disc = 1'b0, clr = 1'b0, fail = 1'b0, servo_off_all, busy;
	logic [15:0]    rdata, err, link = 16'hffff, motion = 16'h0000, homing = 16'h0000;
	logic [3:0]     dly = 4'h0;
	samm_mem_req_s  mreq = '0;
	samm_net_req_s  nreq;
	samm_net_resp_s nresp;
	int             mismatches = 0, compares = 0;
	always #12.5 sys_clk = ~sys_clk;
	samm_mailbox u_dut (.sys_clk(sys_clk), .rstn(rstn), .mem_req(mreq), .mem_rdata(rdata),
		.axis_link_present_flag(link), .axis_motion_active_flag(motion), .axis_homing_flag(homing),
		.net_disconnect_err(disc), .axis_err_clear(clr), .net_req(nreq), .net_resp(nresp),
		.axis_net_error(err), .servo_off_all(servo_off_all), .busy(busy));
	samm_amp_model u_amp (.sys_clk(sys_clk), .rstn(rstn), .net_req(nreq), .dly(dly), .fail(fail), .net_resp(nresp));
	function automatic bit listed(input logic [7:0] c);
		return c inside {[8'h01:8'h02], [8'h04:8'h0a], 8'h0c, 8'h11, 8'h12, [8'h21:8'h26], [8'h31:8'h34],
			[8'h41:8'h43], [8'h61:8'h69], 8'h71, 8'h81};
	endfunction
	task automatic chk(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One access; read data is settled one cycle after the strobe
	task automatic acc(input logic w, input logic [7:0] b, input logic [15:0] a, d);
		@(posedge sys_clk) mreq <= '{wr: w, rd: !w, bank: b, addr: a, wdata: d};
		@(posedge sys_clk) mreq <= '0;
		#1;
	endtask
	task automatic req(input logic [7:0] b, input logic [15:0] id, code, st);
		logic [15:0] base, lo;
		int n;
		base = b == 8'h00 ? 16'h0390 : 16'h0000;
		acc(1, b, base, id);
		acc(1, b, base + 16'h1, code);
		// Poll first: the last read may already hold a stale zero
		n = 0;
		do begin
			acc(0, b, base + 16'h1, 16'h0);
			n++;
		end while (n < 100 && rdata !== 16'h0000);
		if (rdata !== 16'h0000) begin
			chk(1, 0);
			tally_and_finish;
		end else begin
			acc(0, b, base + 16'h2, 16'h0);
			chk(rdata, st);
			if (b == 8'h00 && st == 16'h0002) begin
				acc(0, b, base + 16'h4, 16'h0);
				lo = rdata;
				acc(0, b, base + 16'h5, 16'h0);
				chk({rdata, lo}, {code[7:0], 8'h5a, id});
			end
		end
	endtask
	initial begin
		void'($urandom(3));
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		acc(0, 8'h00, 16'h0393, 16'h0);
		chk(rdata, 16'h0000);
		for (int c = 1; c < 8'h88; c++) begin
			@(posedge sys_clk) motion <= 16'($urandom);
			@(posedge sys_clk) dly <= 4'($urandom);
			req(8'h00, 16'($urandom_range(15)), 16'(c), listed(8'(c)) ? 16'h0002 : 16'h0004);
		end
		@(posedge sys_clk) homing <= 16'h0008;
		req(8'h00, 16'h0003, 16'h0001, 16'h0004);
		@(posedge sys_clk) homing <= 16'h0000;
		@(posedge sys_clk) disc <= 1'b1;
		req(8'h00, 16'h0003, 16'h0001, 16'h0004);
		@(posedge sys_clk) disc <= 1'b0;
		// Link lost after the send: the pending answer must not end normally
		@(posedge sys_clk) dly <= 4'hf;
		fork
			req(8'h00, 16'h0003, 16'h0063, 16'h0006);
			begin
				repeat (8) @(posedge sys_clk);
				disc <= 1'b1;
			end
		join
		@(posedge sys_clk) disc <= 1'b0;
		req(8'h00, 16'h0013, 16'h0001, 16'h0004);
		@(posedge sys_clk) link <= 16'hfff7;
		req(8'h00, 16'h0003, 16'h0001, 16'h0004);
		@(posedge sys_clk) link <= 16'h0f0f;
		@(posedge sys_clk) fail <= 1'b1;
		req(8'h00, 16'h0003, 16'h0063, 16'h0006);
		@(posedge sys_clk) fail <= 1'b0;
		req(8'h52, 16'h0003, 16'h0005, 16'h0004);
		@(posedge sys_clk) motion <= 16'h0000;
		@(posedge sys_clk) fail <= 1'b1;
		req(8'h52, 16'h0003, 16'h0006, 16'h0006);
		chk({servo_off_all, err}, 17'h0);
		@(posedge sys_clk) fail <= 1'b0;
		req(8'h52, 16'h0003, 16'h0006, 16'h0002);
		chk(err, link);
		chk(servo_off_all, 1'b1);
		@(posedge sys_clk) clr <= 1'b1;
		@(posedge sys_clk) clr <= 1'b0;
		#1;
		chk({servo_off_all, err}, 17'h0);
		tally_and_finish;
	end
endmodule
